// ===== dv/fdd_field_load.sv
// fdd_field_load: the field winding as seen from the high side driver.
// assumes field_on comes from the design; the bench commands a short.
`timescale 1ns/10ps
`default_nettype none
module fdd_field_load (
   // clock
   input  wire logic clk,
   // drive and fault control
   input  wire logic field_on,
   input  wire logic short_en,
   // current sense back to the driver
   output logic      overcurrent
);
   // ==========================================
   // winding current: ramps while driven, freewheels down when released
   int unsigned amps = 0;
   always @(posedge clk) begin
      if (field_on && amps < 1000) amps <= amps + 1;
      else if (!field_on && amps > 0) amps <= amps - 1;
   end
   // sense works only while driven; a healthy winding never trips it
   assign overcurrent = field_on && short_en;
endmodule
`default_nettype wire

// ===== dv/field_driver_duty_control_bench.sv
// field_driver_duty_control_bench: self-checking bench of fdd_field_ctrl.
// assumes short counts set by parameter; the winding model gives the sense.
`timescale 1ns/10ps
`default_nettype none
module field_driver_duty_control_bench;
   localparam int unsigned PER [4]  = '{160, 120, 80, 40};
   localparam int unsigned STEP [8] = '{3, 4, 5, 6, 7, 8, 9, 10};
   localparam int unsigned RETRY    = 200;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  ce = 1'b1;
   logic                  short_en = 1'b0;
   logic                  overcurrent;
   logic                  field_on;
   fdd_pkg::fdd_cfg_t     cfg = '0;
   fdd_pkg::fdd_mode_in_t mode_in = '0;
   fdd_pkg::fdd_status_t  status;
   int                    miscompares = 0;
   int                    check_count = 0;
   int                    cycles = 0;

   // ==========================================
   // design and winding
   fdd_field_ctrl #(.PWM_PERIOD_CYC(PER), .RAMP_STEP_CYC(STEP), .RETRY_CYC(RETRY),
      .SAMPLE_CYC(50)) i_fdd_field_ctrl (.clk(clk), .rst(rst), .ce(ce), .cfg(cfg),
      .mode_in(mode_in), .overcurrent(overcurrent), .field_on(field_on), .status(status));
   fdd_field_load i_fdd_field_load (.clk(clk), .field_on(field_on), .short_en(short_en),
      .overcurrent(overcurrent));

   // clock, 100 ns period
   initial begin
      forever #50 clk = ~clk;
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      if (miscompares == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   task automatic edge1();
      @(posedge clk);
      #1;
   endtask

   // model of the fixed modes: pre-excitation first, then self-start
   task automatic apply(input logic pre, input logic ph, input int spd);
      int st;
      int du;
      @(posedge clk);
      mode_in.preexcite  <= pre;
      mode_in.phase_only <= ph;
      mode_in.speed_rpm  <= 16'(spd);
      st = pre ? 2 : (ph && spd < fdd_pkg::SS_LIMIT_RPM[cfg.selfstart_speed_limit]) ? 4 : 1;
      du = (st == 2) ? 125 : (st == 4) ? 60 : int'(mode_in.reg_duty);
      edge1();
      check(16'(status.state), 16'(st), "state");
      check(16'(status.duty), 16'(du), "duty");
   endtask

   // ==========================================
   // main sequence
   initial begin
      int n;
      int d;
      int lim;
      void'($urandom(32'h1C15353B));
      mode_in.reg_duty  <= 10'h12C;
      mode_in.speed_rpm <= 16'h0FA0;
      repeat (15) @(posedge clk);
      #1;
      check(16'(status), 16'h0800, "reset status");
      check(16'(field_on), 16'h0000, "reset field");
      @(posedge clk);
      rst <= 1'b0;
      edge1();
      check(16'(status), 16'h092C, "first edge");
      // pwm on-time at every frequency, in pre-excitation
      apply(1'b1, 1'b0, 4000);
      for (int f = 0; f < 4; f++) begin
         @(posedge clk);
         cfg.field_pwm_frequency_option <= 2'(f);
         repeat (2 * PER[0] + 4) @(posedge clk);
         n = 0;
         repeat (4 * PER[f]) begin
            edge1();
            n += int'(field_on === 1'b1);
         end
         check(16'(n), 16'(4 * (PER[f] * 125 / 1000)), "on time");
      end
      // self-start window for each speed limit, random speeds below it
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         cfg.selfstart_speed_limit <= 2'(k);
         lim = fdd_pkg::SS_LIMIT_RPM[k];
         apply(1'b0, 1'b1, $urandom_range(lim - 1, 0));
         apply(1'b1, 1'b1, 0);
         apply(1'b0, 1'b0, 100);
         apply(1'b0, 1'b1, lim - 1);
         apply(1'b0, 1'b1, lim);
      end
      // ramp: no trigger at exactly the threshold, then blind zone and slope
      @(posedge clk);
      mode_in.phase_only <= 1'b0;
      mode_in.speed_rpm  <= 16'($urandom_range(1499, 0));
      for (int o = 0; o < 8; o++) begin
         @(posedge clk);
         cfg.ramp_up_duration_option <= 3'(o);
         cfg.lrc_speed_option        <= 2'($urandom_range(3, 0));
         mode_in.reg_duty            <= 10'h064;
         repeat (120) @(posedge clk);
         mode_in.reg_duty <= 10'h0A7;
         repeat (120) @(posedge clk);
         #1;
         check(16'(status.state), 16'(fdd_pkg::ST_NORMAL), "no ramp");
         check(16'(status.duty), 16'h00A7, "no ramp duty");
         @(posedge clk);
         mode_in.reg_duty <= 10'h190;
         n = 0;
         while (status.state !== fdd_pkg::ST_RAMP && n < 60) begin
            edge1();
            n++;
         end
         check(16'(status.state), 16'(fdd_pkg::ST_RAMP), "ramp start");
         check(16'(status.duty), 16'(167 + 53), "ramp first");
         for (int s = 0; s < 2; s++) begin
            d = int'(status.duty);
            n = 0;
            while (status.duty === 10'(d) && n < 20) begin
               edge1();
               n++;
            end
            check(16'(n), 16'(STEP[o]), "step time");
            check(16'(status.duty), 16'(d + 1), "step size");
         end
         n = 0;
         while (status.state !== fdd_pkg::ST_NORMAL && n < 2000) begin
            edge1();
            n++;
         end
         check(16'(status.state), 16'(fdd_pkg::ST_NORMAL), "ramp over");
         check(16'(status.duty), 16'h0190, "ramp end");
      end
      // over-current on a full-on field: filter, shutdown, retry
      @(posedge clk);
      mode_in.speed_rpm <= 16'h0FA0;
      mode_in.reg_duty  <= 10'h3E8;
      repeat (200) @(posedge clk);
      #1;
      check(16'(field_on), 16'h0001, "full on");
      @(posedge clk);
      short_en <= 1'b1;
      n = 0;
      while (status.oc_off !== 1'b1 && n < 100) begin
         edge1();
         n++;
      end
      check(16'(n), 16'h0032, "filter");
      check(16'(field_on), 16'h0000, "field off");
      @(posedge clk);
      short_en <= 1'b0;
      n = 1;
      #1;
      while (status.oc_off === 1'b1 && n < 400) begin
         edge1();
         n++;
      end
      check(16'(n), 16'(RETRY), "retry");
      repeat (50) edge1();
      check(16'(field_on), 16'h0001, "retried");
      // clock enable low must freeze the mode machine even against a request
      @(posedge clk);
      ce                <= 1'b0;
      mode_in.preexcite <= 1'b1;
      repeat (20) edge1();
      check(16'(status.state), 16'(fdd_pkg::ST_NORMAL), "frozen");
      @(posedge clk);
      ce <= 1'b1;
      edge1();
      check(16'(status.state), 16'(fdd_pkg::ST_PREEX), "thawed");
      conclude();
   end
endmodule
`default_nettype wire

// ===== logic/fdd_field_ctrl.sv
// fdd_field_ctrl: field driver duty control with over-current retry.
// assumes speed, mode requests and regulation duty come synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module fdd_field_ctrl #(
   parameter int unsigned PWM_PERIOD_CYC [4] = fdd_pkg::PWM_PERIOD_CYC,
   parameter int unsigned RAMP_STEP_CYC [8]  = fdd_pkg::RAMP_STEP_CYC,
   parameter int unsigned RETRY_CYC          = fdd_pkg::RETRY_CYC,
   parameter int unsigned SAMPLE_CYC         = fdd_pkg::SAMPLE_CYC
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   // configuration and mode inputs
   input  wire fdd_pkg::fdd_cfg_t    cfg,
   input  wire fdd_pkg::fdd_mode_in_t mode_in,
   // driver feedback
   input  wire logic                 overcurrent,
   // outputs
   output logic                      field_on,
   output fdd_pkg::fdd_status_t      status
);
   // ==========================================
   // helpers
   function automatic fdd_pkg::fdd_duty_t sat_add(input fdd_pkg::fdd_duty_t a, input fdd_pkg::fdd_duty_t b);
      logic [10:0] s;
      s = {1'b0, a} + {1'b0, b};
      return (s > {1'b0, fdd_pkg::DUTY_FULL}) ? fdd_pkg::DUTY_FULL : s[9:0];
   endfunction

   // ==========================================
   // declarations
   fdd_pkg::fdd_cnt_t   oc_cnt_reg, oc_cnt_next;
   fdd_pkg::fdd_cnt_t   retry_cnt_reg, retry_cnt_next;
   logic                oc_off_reg, oc_off_next;
   fdd_pkg::fdd_cnt_t   tick_cnt_reg, tick_cnt_next;
   fdd_pkg::fdd_cnt_t   step_cnt_reg, step_cnt_next;
   fdd_pkg::fdd_state_t state_reg, state_next;
   fdd_pkg::fdd_duty_t  duty_reg, duty_next;
   fdd_pkg::fdd_duty_t  prev_sample_reg, prev_sample_next;
   logic                field_on_reg, field_on_next;
   logic                pwm_raw;
   logic                below_ss, low_speed, ss_cond, override;
   logic                sample_tick, step_tick, rise_trig, ramp_done;
   fdd_pkg::fdd_duty_t  demand;

   // ==========================================
   // decodes of the inputs
   always_comb begin
      demand      = (mode_in.reg_duty > fdd_pkg::DUTY_FULL) ? fdd_pkg::DUTY_FULL : mode_in.reg_duty;
      below_ss    = (mode_in.speed_rpm < fdd_pkg::SS_LIMIT_RPM[cfg.selfstart_speed_limit]);
      low_speed   = (mode_in.speed_rpm < fdd_pkg::LRC_SPEED_RPM[cfg.lrc_speed_option]);
      ss_cond     = mode_in.phase_only && below_ss;
      override    = mode_in.preexcite || ss_cond;
      sample_tick = (tick_cnt_reg >= fdd_pkg::fdd_cnt_t'(SAMPLE_CYC - 1));
      step_tick   = (step_cnt_reg >= fdd_pkg::fdd_cnt_t'(RAMP_STEP_CYC[cfg.ramp_up_duration_option] - 1));
      // only a rise counts; a falling demand never starts the ramp
      rise_trig   = (demand > prev_sample_reg) && ((demand - prev_sample_reg) > fdd_pkg::TRIG_THR);
      ramp_done   = (duty_reg >= demand) || (duty_reg == fdd_pkg::DUTY_FULL);
   end

   // ==========================================
   // over-current filter and retry timer
   always_comb begin
      oc_cnt_next    = '0;
      retry_cnt_next = '0;
      oc_off_next    = oc_off_reg;
      if (oc_off_reg) begin
         // the driver stays off for the whole retry time, whatever the input does
         if (retry_cnt_reg >= fdd_pkg::fdd_cnt_t'(RETRY_CYC - 1)) begin
            oc_off_next = 1'b0;
         end else begin
            retry_cnt_next = retry_cnt_reg + 20'h00001;
         end
      end else if (overcurrent) begin
         if (oc_cnt_reg >= fdd_pkg::fdd_cnt_t'(fdd_pkg::OC_FILTER_CYC - 1)) begin
            oc_off_next = 1'b1;
         end else begin
            oc_cnt_next = oc_cnt_reg + 20'h00001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         oc_cnt_reg    <= '0;
         retry_cnt_reg <= '0;
         oc_off_reg    <= 1'b0;
      end else if (ce) begin
         oc_cnt_reg    <= oc_cnt_next;
         retry_cnt_reg <= retry_cnt_next;
         oc_off_reg    <= oc_off_next;
      end
   end

   // ==========================================
   // sample tick and ramp step timers
   always_comb begin
      tick_cnt_next    = sample_tick ? '0 : tick_cnt_reg + 20'h00001;
      prev_sample_next = sample_tick ? demand : prev_sample_reg;
      step_cnt_next    = (state_reg != fdd_pkg::ST_RAMP || step_tick) ? '0 : step_cnt_reg + 20'h00001;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt_reg    <= '0;
         prev_sample_reg <= '0;
         step_cnt_reg    <= '0;
      end else if (ce) begin
         tick_cnt_reg    <= tick_cnt_next;
         prev_sample_reg <= prev_sample_next;
         step_cnt_reg    <= step_cnt_next;
      end
   end

   // ==========================================
   // mode machine and duty selection
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         fdd_pkg::ST_NORMAL: begin
            if (sample_tick && low_speed && rise_trig) begin
               state_next = fdd_pkg::ST_RAMP;
            end
         end
         fdd_pkg::ST_RAMP: begin
            // a started ramp finishes even if speed rises above the low-speed band
            if (ramp_done) begin
               state_next = fdd_pkg::ST_NORMAL;
            end
         end
         fdd_pkg::ST_PREEX: state_next = fdd_pkg::ST_NORMAL;
         fdd_pkg::ST_SELFSTART: state_next = fdd_pkg::ST_NORMAL;
         default: state_next = fdd_pkg::ST_NORMAL;
      endcase
      if (mode_in.preexcite) begin
         state_next = fdd_pkg::ST_PREEX;
      end else if (ss_cond) begin
         state_next = fdd_pkg::ST_SELFSTART;
      end

      duty_next = demand;
      unique case (state_next)
         fdd_pkg::ST_PREEX: duty_next = fdd_pkg::PREEX_DUTY;
         fdd_pkg::ST_SELFSTART: duty_next = fdd_pkg::SS_DUTY;
         fdd_pkg::ST_NORMAL: duty_next = demand;
         fdd_pkg::ST_RAMP: begin
            if (state_reg != fdd_pkg::ST_RAMP) begin
               duty_next = sat_add(prev_sample_reg, fdd_pkg::BZ_STEP);
            end else if (step_tick) begin
               duty_next = sat_add(duty_reg, 10'h001);
            end else begin
               duty_next = duty_reg;
            end
         end
         default: duty_next = demand;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= fdd_pkg::ST_NORMAL;
         duty_reg  <= '0;
      end else if (ce) begin
         state_reg <= state_next;
         duty_reg  <= duty_next;
      end
   end

   // ==========================================
   // pwm timebase
   fdd_pwm u_pwm (
      .clk    (clk),
      .rst    (rst),
      .ce     (ce),
      .period (fdd_pkg::fdd_cnt_t'(PWM_PERIOD_CYC[cfg.field_pwm_frequency_option])),
      .duty   (duty_reg),
      .pwm_on (pwm_raw)
   );

   // ==========================================
   // field output, gated by the shutdown in the same edge it is raised
   always_comb begin
      field_on_next = pwm_raw && !oc_off_next;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         field_on_reg <= 1'b0;
      end else if (ce) begin
         field_on_reg <= field_on_next;
      end
   end

   assign field_on = field_on_reg;
   assign status   = '{state: state_reg, oc_off: oc_off_reg, duty: duty_reg};

   // ==========================================
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_oc_field_off: assert property (oc_off_reg |-> !field_on_reg)
      else $error("field on during over-current shutdown");
   a_oc_filter_len: assert property ($rose(oc_off_reg) |-> $past(oc_cnt_reg) == fdd_pkg::OC_FILTER_CYC - 1)
      else $error("shutdown before filter time");
   a_oc_retry_wait: assert property ($fell(oc_off_reg) |-> $past(retry_cnt_reg) == RETRY_CYC - 1)
      else $error("retry before retry time");
   a_preex_duty: assert property (state_reg == fdd_pkg::ST_PREEX |-> duty_reg == fdd_pkg::PREEX_DUTY)
      else $error("wrong pre-excitation duty");
   a_ss_duty: assert property (state_reg == fdd_pkg::ST_SELFSTART |-> duty_reg == fdd_pkg::SS_DUTY)
      else $error("wrong self-start duty");
   a_ss_entry: assert property ((ce && !mode_in.preexcite && mode_in.phase_only && below_ss)
      |=> state_reg == fdd_pkg::ST_SELFSTART)
      else $error("self-start not entered");
   a_ss_exit: assert property ((ce && state_reg == fdd_pkg::ST_SELFSTART && !override)
      |=> state_reg == fdd_pkg::ST_NORMAL && duty_reg == $past(demand))
      else $error("self-start not left above speed limit");
   a_ramp_trigger: assert property ((ce && state_reg == fdd_pkg::ST_NORMAL && !override && sample_tick
      && low_speed && rise_trig) |=> state_reg == fdd_pkg::ST_RAMP)
      else $error("ramp not triggered");
   a_ramp_start: assert property ($rose(state_reg == fdd_pkg::ST_RAMP)
      |-> duty_reg == sat_add($past(prev_sample_reg), fdd_pkg::BZ_STEP))
      else $error("ramp start duty wrong");
   a_ramp_slope: assert property ((ce && state_reg == fdd_pkg::ST_RAMP && state_next == fdd_pkg::ST_RAMP
      && step_tick) |=> duty_reg == sat_add($past(duty_reg), 10'h001))
      else $error("ramp step wrong");
endmodule
`default_nettype wire

// ===== logic/fdd_pkg.sv
// fdd_pkg: constants, types and timing counts of the field duty control.
// assumes a single 10 MHz clock; duty is held in tenths of a percent.
package fdd_pkg;
   // ==========================================
   // clock and widths
   localparam int unsigned CLK_HZ       = 10_000_000;
   localparam int unsigned CLK_KHZ      = CLK_HZ / 1000;
   localparam int unsigned CLK_NS       = 100;
   typedef logic [19:0] fdd_cnt_t;
   typedef logic [9:0]  fdd_duty_t;

   // ==========================================
   // duty figures, per mille
   localparam fdd_duty_t DUTY_FULL  = 10'h3E8; // 100 %
   localparam fdd_duty_t PREEX_DUTY = 10'h07D; // 12.5 %
   localparam fdd_duty_t SS_DUTY    = 10'h03C; // 6 %
   localparam fdd_duty_t BZ_STEP    = 10'h035; // 5.3 %
   localparam fdd_duty_t TRIG_THR   = 10'h043; // 6.7 %

   // ==========================================
   // timing, figure in its own unit then cycles
   localparam int unsigned OC_FILTER_NS  = 5000;
   localparam int unsigned OC_FILTER_CYC = (OC_FILTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RETRY_MS      = 40;
   localparam int unsigned RETRY_CYC     = RETRY_MS * CLK_KHZ;
   localparam int unsigned SAMPLE_MS     = 1;
   localparam int unsigned SAMPLE_CYC    = SAMPLE_MS * CLK_KHZ;
   localparam int unsigned PWM_FREQ_HZ [4] = '{125, 250, 333, 400};
   localparam int unsigned PWM_PERIOD_CYC [4] = '{CLK_HZ / PWM_FREQ_HZ[0], CLK_HZ / PWM_FREQ_HZ[1],
                                                  CLK_HZ / PWM_FREQ_HZ[2], CLK_HZ / PWM_FREQ_HZ[3]};
   // full 0..100 % ramp time; one per-mille step every RAMP_UP_MS*CLK_KHZ/1000 cycles
   localparam int unsigned RAMP_UP_MS [8] = '{2500, 3000, 5000, 6000, 7500, 9000, 10000, 12000};
   localparam int unsigned RAMP_STEP_CYC [8] = '{
      RAMP_UP_MS[0] * CLK_KHZ / 1000, RAMP_UP_MS[1] * CLK_KHZ / 1000,
      RAMP_UP_MS[2] * CLK_KHZ / 1000, RAMP_UP_MS[3] * CLK_KHZ / 1000,
      RAMP_UP_MS[4] * CLK_KHZ / 1000, RAMP_UP_MS[5] * CLK_KHZ / 1000,
      RAMP_UP_MS[6] * CLK_KHZ / 1000, RAMP_UP_MS[7] * CLK_KHZ / 1000};

   // ==========================================
   // speed thresholds, rpm
   localparam int unsigned SS_LIMIT_RPM [4]  = '{1200, 1500, 2800, 3200};
   localparam int unsigned LRC_SPEED_RPM [4] = '{1500, 2800, 3000, 3200};

   // ==========================================
   // types
   typedef enum logic [3:0] {
      ST_NORMAL    = 4'h1,
      ST_PREEX     = 4'h2,
      ST_SELFSTART = 4'h4,
      ST_RAMP      = 4'h8
   } fdd_state_t;

   typedef struct packed {
      logic [1:0] field_pwm_frequency_option;
      logic [2:0] ramp_up_duration_option;
      logic [1:0] selfstart_speed_limit;
      logic [1:0] lrc_speed_option;
   } fdd_cfg_t;

   typedef struct packed {
      logic       preexcite;
      logic       phase_only;
      logic [15:0] speed_rpm;
      fdd_duty_t  reg_duty;
   } fdd_mode_in_t;

   typedef struct packed {
      fdd_state_t state;
      logic       oc_off;
      fdd_duty_t  duty;
   } fdd_status_t;
endpackage

// ===== logic/fdd_pwm.sv
// fdd_pwm: field pwm timebase, one on-phase per period.
// assumes period and duty stable enough; both are taken at period start only.
`timescale 1ns/10ps
`default_nettype none
module fdd_pwm (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // settings
   input  wire fdd_pkg::fdd_cnt_t  period,
   input  wire fdd_pkg::fdd_duty_t duty,
   // output
   output logic                   pwm_on
);
   // ==========================================
   // on-time from period and duty
   function automatic fdd_pkg::fdd_cnt_t on_time(input fdd_pkg::fdd_cnt_t p, input fdd_pkg::fdd_duty_t d);
      logic [29:0] prod;
      prod = p * d;
      return fdd_pkg::fdd_cnt_t'(prod / fdd_pkg::DUTY_FULL);
   endfunction

   fdd_pkg::fdd_cnt_t cnt_reg, cnt_next;
   fdd_pkg::fdd_cnt_t per_reg, per_next;
   fdd_pkg::fdd_cnt_t ton_reg, ton_next;
   logic              on_reg, on_next;
   logic              wrap;

   // ==========================================
   // next period count; settings are latched at the wrap so a period is never cut
   always_comb begin
      wrap     = (cnt_reg >= per_reg - 20'h00001);
      cnt_next = wrap ? '0 : cnt_reg + 20'h00001;
      per_next = per_reg;
      ton_next = ton_reg;
      if (wrap) begin
         per_next = period;
         ton_next = on_time(period, duty);
      end
      on_next = (cnt_next < ton_next);
   end

   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         // a one-cycle period wraps at the first edge, so the configured period is taken at once
         per_reg <= 20'h00001;
         ton_reg <= '0;
         on_reg  <= 1'b0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
         per_reg <= per_next;
         ton_reg <= ton_next;
         on_reg  <= on_next;
      end
   end

   assign pwm_on = on_reg;
endmodule
`default_nettype wire
